// [src/tto_cycle_timer.sv]
// Run/clear cycle counter that raises a level once a limit is reached.
`timescale 1ns/1ns
`default_nettype none
module tto_cycle_timer
    import tto_pkg::*;
#(
    parameter int WIDTH = 18,
    parameter int LIMIT = 200000
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic run,
    input wire logic clear,
    output logic done_ff
);
    logic [WIDTH-1:0] cnt_ff;
    logic [WIDTH-1:0] nxt_cnt;
    logic nxt_done;
    wire at_limit = (cnt_ff == WIDTH'(LIMIT - 1));

    // ========================================================
    // Counting
    assign nxt_cnt = clear ? '0 :
        (run && !at_limit) ? cnt_ff + WIDTH'(1) : cnt_ff;
    assign nxt_done = clear ? 1'b0 : (done_ff || (run && at_limit));

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnt_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end
endmodule // tto_cycle_timer
`default_nettype wire

// [src/tto_monitor.sv]
// Thermal threshold, hysteresis and out-of-spec monitor for one thread.
// Function
// R1: New thresholds take effect at next sample.
// R2: Reprogramming onto current temperature raises nothing.
// R3: Crossing new threshold interrupts at next update.
// R4: Two seven-bit threshold offset fields.
// R5: Two threshold enables plus out-of-spec enable.
// R6: All defined control bits read and write.
// R7: Hot state uses separate hot and cold levels.
// R8: Offsets subtract from the trip temperature.
// R9: Interrupt needs crossing, enable and unmasked vector.
// R10: Crossings interrupt in both directions.
// R11: Catastrophic trips ORed onto active-low pin.
// R12: Catastrophic pin works whenever powered after reset.
// R13: Temperature refreshes at most once per millisecond.
// R14: Interrupts and hot pin change only per refresh.
// R15: Out-of-spec status and log clear only on reset.
// R16: Out-of-spec after 10 ms hot at lowest point.
// R17: Forced power reduction time does not advance timer.
// R18: Timer starts only once lowest state reached.
// R19: Timer clears when temperature falls below trip.
// R20: Out-of-spec when near the catastrophic temperature.
// R21: Threshold change updates status, not log bits.
// R22: Each refresh updates status and logs crossings.
// R23: A raised interrupt is delivered regardless of changes.
`timescale 1ns/1ns
`default_nettype none
module tto_monitor
    import tto_pkg::*;
#(
    parameter int NUM_SENSORS = 4,
    parameter int SAMPLE_CYC = TTO_SAMPLE_CYC,
    parameter int OOS_CYC = TTO_OOS_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [31:0] msr_addr,
    input wire logic msr_rd,
    input wire logic msr_wr,
    input wire logic [63:0] msr_wdata,
    output logic [63:0] msr_rdata_ff,
    output logic msr_rvalid_ff,
    input wire logic [TTO_TEMP_W-1:0] sensor_temp,
    input wire logic [NUM_SENSORS-1:0] sensor_cat_trip,
    input wire logic local_thermal_vector_entry,
    input wire logic lowest_vf_settled,
    input wire logic forced_power_reduction_in,
    output logic thermal_irq_ff,
    output logic hot_indicator_n_ff,
    output logic out_of_spec_condition_ff,
    output logic catastrophic_trip_out_n
);
    // ========================================================
    // Helper functions
    function automatic logic [7:0] thr_of(input logic [6:0] off);
        thr_of = (TTO_TRIP_TEMP > {1'b0, off}) ?
            TTO_TRIP_TEMP - {1'b0, off} : 8'h00;
    endfunction

    function automatic logic at_or_above(input logic [7:0] t,
                                         input logic [7:0] lvl);
        at_or_above = (t >= lvl);
    endfunction

    // ========================================================
    // State
    logic [63:0] thermal_threshold_control_ff;
    logic [63:0] nxt_ctrl;
    logic [6:0] act_off1_ff;
    logic [6:0] act_off2_ff;
    logic [7:0] temp_ff;
    logic [7:0] prev_temp_ff;
    logic eval_ff;
    logic primed_ff;
    logic hot_ff;
    logic thr1_ff;
    logic thr2_ff;
    logic hot_log_ff;
    logic thr1_log_ff;
    logic thr2_log_ff;
    logic oos_told_ff;
    logic fpr_meta_ff;
    logic fpr_sync_ff;
    logic tick;
    logic oos_done;
    logic nxt_hot;
    logic nxt_oos;
    logic nxt_irq;
    logic [63:0] thermal_status_register;
    logic [63:0] nxt_rdata;

    // ========================================================
    // Sample tick and out-of-spec timers
    tto_cycle_timer #(
        .WIDTH($clog2(SAMPLE_CYC + 1)),
        .LIMIT(SAMPLE_CYC - 1)
    ) u_sample (
        .core_clk(core_clk),
        .reset(reset),
        .run(1'b1),
        .clear(tick),
        .done_ff(tick)
    );

    wire above_trip = (temp_ff > TTO_TRIP_TEMP);
    wire below_trip = (temp_ff < TTO_TRIP_TEMP);
    wire oos_run = above_trip && lowest_vf_settled && !fpr_sync_ff; // see R17
    wire oos_clr = below_trip // see R19
        || (!lowest_vf_settled && !fpr_sync_ff); // see R18

    tto_cycle_timer #(
        .WIDTH($clog2(OOS_CYC + 1)),
        .LIMIT(OOS_CYC)
    ) u_oos (
        .core_clk(core_clk),
        .reset(reset),
        .run(oos_run),
        .clear(oos_clr),
        .done_ff(oos_done)
    );

    // ========================================================
    // Threshold comparison
    wire [7:0] thr1_lvl = thr_of(act_off1_ff); // see R8
    wire [7:0] thr2_lvl = thr_of(act_off2_ff); // see R8
    wire st1_now = at_or_above(temp_ff, thr1_lvl);
    wire st2_now = at_or_above(temp_ff, thr2_lvl);
    wire st1_prev = at_or_above(prev_temp_ff, thr1_lvl);
    wire st2_prev = at_or_above(prev_temp_ff, thr2_lvl);
    // Both samples are judged against the new level, so a rewrite alone
    // shows no direction, while a real move across it does.
    wire cross1 = eval_ff && primed_ff && (st1_now != st1_prev); // see R2 R3
    wire cross2 = eval_ff && primed_ff && (st2_now != st2_prev); // see R10

    wire [8:0] hot_lvl = {1'b0, TTO_TRIP_TEMP} + {1'b0, TTO_HOT_MARGIN};
    wire [8:0] cold_lvl = {1'b0, TTO_TRIP_TEMP} - {1'b0, TTO_COLD_MARGIN};
    assign nxt_hot = ({1'b0, temp_ff} >= hot_lvl) ? 1'b1 : // see R7
        ({1'b0, temp_ff} <= cold_lvl) ? 1'b0 : hot_ff;
    wire hot_rise = eval_ff && nxt_hot && !hot_ff;
    wire hot_fall = eval_ff && !nxt_hot && hot_ff;

    wire [8:0] oos_lvl = {1'b0, TTO_CAT_TEMP} - {1'b0, TTO_OOS_MARGIN};
    assign nxt_oos = out_of_spec_condition_ff || oos_done // see R15 R16
        || ({1'b0, temp_ff} >= oos_lvl); // see R20

    // ========================================================
    // Interrupt decision
    wire [63:0] c = thermal_threshold_control_ff;
    wire thr_ev = (cross1 && c[TTO_CTRL_THR1_EN])
        || (cross2 && c[TTO_CTRL_THR2_EN])
        || (hot_rise && c[TTO_CTRL_HIGH_EN])
        || (hot_fall && c[TTO_CTRL_LOW_EN]);
    wire oos_ev = eval_ff && out_of_spec_condition_ff && !oos_told_ff
        && c[TTO_CTRL_OOS_EN];
    assign nxt_irq = local_thermal_vector_entry && (thr_ev || oos_ev); // see R9

    // ========================================================
    // Register access
    wire wr_ctrl = msr_wr && (msr_addr == TTO_CTRL_ADDR);
    wire wr_stat = msr_wr && (msr_addr == TTO_STAT_ADDR);
    assign nxt_ctrl = wr_ctrl ? (msr_wdata & TTO_CTRL_MASK) // see R4 R5 R6
        : thermal_threshold_control_ff;

    wire [7:0] readout = above_trip ? 8'h00 : TTO_TRIP_TEMP - temp_ff;
    always_comb begin
        thermal_status_register = '0;
        thermal_status_register[TTO_STAT_HOT] = hot_ff;
        thermal_status_register[TTO_STAT_HOT_LOG] = hot_log_ff;
        thermal_status_register[TTO_STAT_OOS] = out_of_spec_condition_ff;
        thermal_status_register[TTO_STAT_OOS_LOG] = out_of_spec_condition_ff;
        thermal_status_register[TTO_STAT_THR1] = thr1_ff;
        thermal_status_register[TTO_STAT_THR1_LOG] = thr1_log_ff;
        thermal_status_register[TTO_STAT_THR2] = thr2_ff;
        thermal_status_register[TTO_STAT_THR2_LOG] = thr2_log_ff;
        thermal_status_register[TTO_STAT_READ_LSB +: TTO_OFFSET_W] =
            (readout[7] ? 7'h7f : readout[6:0]);
    end

    assign nxt_rdata = (msr_addr == TTO_CTRL_ADDR) ?
        thermal_threshold_control_ff :
        (msr_addr == TTO_STAT_ADDR) ? thermal_status_register : '0;

    // Software clears a log bit by writing zero; a new event wins.
    wire clr_hot = wr_stat && !msr_wdata[TTO_STAT_HOT_LOG];
    wire clr_thr1 = wr_stat && !msr_wdata[TTO_STAT_THR1_LOG]; // see R21
    wire clr_thr2 = wr_stat && !msr_wdata[TTO_STAT_THR2_LOG]; // see R21

    // ========================================================
    // Registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fpr_meta_ff <= 1'b0;
            fpr_sync_ff <= 1'b0;
        end else begin
            fpr_meta_ff <= forced_power_reduction_in;
            fpr_sync_ff <= fpr_meta_ff;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            thermal_threshold_control_ff <= TTO_CTRL_RESET;
            act_off1_ff <= '0;
            act_off2_ff <= '0;
            temp_ff <= '0;
            prev_temp_ff <= '0;
            eval_ff <= 1'b0;
            primed_ff <= 1'b0;
        end else begin
            thermal_threshold_control_ff <= nxt_ctrl;
            eval_ff <= tick;
            if (tick) begin
                temp_ff <= sensor_temp; // see R13
                prev_temp_ff <= temp_ff;
                act_off1_ff <= c[TTO_CTRL_THR1_LSB +: TTO_OFFSET_W]; // see R1
                act_off2_ff <= c[TTO_CTRL_THR2_LSB +: TTO_OFFSET_W]; // see R1
            end
            if (eval_ff) begin
                primed_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            hot_ff <= 1'b0;
            thr1_ff <= 1'b0;
            thr2_ff <= 1'b0;
            hot_log_ff <= 1'b0;
            thr1_log_ff <= 1'b0;
            thr2_log_ff <= 1'b0;
        end else begin
            if (eval_ff) begin
                hot_ff <= nxt_hot; // see R14
                thr1_ff <= st1_now; // see R22
                thr2_ff <= st2_now; // see R22
            end
            hot_log_ff <= (hot_rise || hot_fall) || (hot_log_ff && !clr_hot);
            thr1_log_ff <= cross1 || (thr1_log_ff && !clr_thr1); // see R22
            thr2_log_ff <= cross2 || (thr2_log_ff && !clr_thr2); // see R22
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            out_of_spec_condition_ff <= 1'b0;
            oos_told_ff <= 1'b0;
            thermal_irq_ff <= 1'b0;
            hot_indicator_n_ff <= 1'b1;
            msr_rdata_ff <= '0;
            msr_rvalid_ff <= 1'b0;
        end else begin
            out_of_spec_condition_ff <= nxt_oos; // see R15
            oos_told_ff <= oos_told_ff || (eval_ff && out_of_spec_condition_ff);
            thermal_irq_ff <= nxt_irq; // see R23
            hot_indicator_n_ff <= !nxt_hot || !eval_ff ?
                (eval_ff ? !nxt_hot : hot_indicator_n_ff) : 1'b0; // see R14
            msr_rdata_ff <= msr_rd ? nxt_rdata : '0;
            msr_rvalid_ff <= msr_rd;
        end
    end

    // Trip path is pure logic so it works with no clock running.
    assign catastrophic_trip_out_n = ~(|sensor_cat_trip); // see R11 R12

    // ========================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence refresh_s;
        tick ##1 eval_ff;
    endsequence

    irq_on_refresh_a: assert property ( // see R14
        thermal_irq_ff |-> $past(eval_ff))
        else $error("Interrupt raised outside a refresh.");
    hot_pin_refresh_a: assert property ( // see R14
        $changed(hot_indicator_n_ff) |-> $past(eval_ff))
        else $error("Hot pin changed outside a refresh.");
    oos_sticky_a: assert property ( // see R15
        out_of_spec_condition_ff |=> out_of_spec_condition_ff)
        else $error("Out-of-spec condition cleared.");
    offset_defer_a: assert property ( // see R1
        $changed(act_off1_ff) || $changed(act_off2_ff) |-> $past(tick))
        else $error("Threshold took effect between samples.");
    trip_or_a: assert property ( // see R11
        catastrophic_trip_out_n == !(|sensor_cat_trip))
        else $error("Catastrophic pin does not follow the trips.");
    oos_margin_a: assert property ( // see R20
        ({1'b0, temp_ff} >= oos_lvl) |=> out_of_spec_condition_ff)
        else $error("Out-of-spec missed near catastrophic level.");
    irq_vector_a: assert property ( // see R9
        thermal_irq_ff |-> $past(local_thermal_vector_entry))
        else $error("Interrupt raised while vector masked.");
    timer_clear_a: assert property ( // see R19
        below_trip |=> !oos_done)
        else $error("Timer kept running below trip.");
    log_cross_a: assert property ( // see R22
        refresh_s ##0 cross1 |=> thr1_log_ff ##0 (thr1_ff == $past(st1_now)))
        else $error("Crossing did not set log and status.");
    refresh_gap_a: assert property ( // see R13
        tick |=> !tick [*2])
        else $error("Temperature refreshed too often.");
endmodule // tto_monitor
`default_nettype wire

// [src/tto_pkg.sv]
// Constants shared by the thermal threshold and out-of-spec monitor.
package tto_pkg;

    // ========================================================
    // Register addresses, control reset value and control write mask
    localparam logic [31:0] TTO_CTRL_ADDR = 32'h0000_019b;
    localparam logic [31:0] TTO_STAT_ADDR = 32'h0000_019c;
    localparam logic [63:0] TTO_CTRL_RESET = 64'h0000_0000_0000_0000;
    localparam logic [63:0] TTO_CTRL_MASK = 64'h0000_0000_00ff_ff13;

    // ========================================================
    // Control register fields
    localparam int TTO_CTRL_HIGH_EN = 0;
    localparam int TTO_CTRL_LOW_EN = 1;
    localparam int TTO_CTRL_OOS_EN = 4;
    localparam int TTO_CTRL_THR1_LSB = 8;
    localparam int TTO_CTRL_THR1_EN = 15;
    localparam int TTO_CTRL_THR2_LSB = 16;
    localparam int TTO_CTRL_THR2_EN = 23;
    localparam int TTO_OFFSET_W = 7;

    // ========================================================
    // Status register fields
    localparam int TTO_STAT_HOT = 0;
    localparam int TTO_STAT_HOT_LOG = 1;
    localparam int TTO_STAT_OOS = 4;
    localparam int TTO_STAT_OOS_LOG = 5;
    localparam int TTO_STAT_THR1 = 6;
    localparam int TTO_STAT_THR1_LOG = 7;
    localparam int TTO_STAT_THR2 = 8;
    localparam int TTO_STAT_THR2_LOG = 9;
    localparam int TTO_STAT_READ_LSB = 16;

    // ========================================================
    // Temperatures and margins in degrees
    localparam int TTO_TEMP_W = 8;
    localparam logic [7:0] TTO_TRIP_TEMP = 8'h64;
    localparam logic [7:0] TTO_CAT_TEMP = 8'h7d;
    localparam logic [7:0] TTO_HOT_MARGIN = 8'h02;
    localparam logic [7:0] TTO_COLD_MARGIN = 8'h02;
    localparam logic [7:0] TTO_OOS_MARGIN = 8'h05;

    // ========================================================
    // Timing
    localparam int TTO_CLK_PERIOD_NS = 50;
    localparam int TTO_SAMPLE_PERIOD_NS = 1000000;
    localparam int TTO_OOS_PERIOD_NS = 10000000;
    localparam int TTO_SAMPLE_CYC =
        (TTO_SAMPLE_PERIOD_NS + TTO_CLK_PERIOD_NS - 1) / TTO_CLK_PERIOD_NS;
    localparam int TTO_OOS_CYC =
        (TTO_OOS_PERIOD_NS + TTO_CLK_PERIOD_NS - 1) / TTO_CLK_PERIOD_NS;

endpackage

// [tb/thermal_threshold_oos_monitor_tb_top.sv]
// Self-checking bench for the thermal threshold and out-of-spec monitor.
`timescale 1ns/1ns
`default_nettype none
module thermal_threshold_oos_monitor_tb_top;
    import tto_pkg::*;
    localparam int SC = 16;
    localparam int OC = 40;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [31:0] msr_addr = TTO_CTRL_ADDR;
    logic msr_rd = 1'b0;
    logic msr_wr = 1'b0;
    logic [63:0] msr_wdata = TTO_CTRL_RESET;
    logic [63:0] msr_rdata_ff;
    logic msr_rvalid_ff;
    logic [3:0] sensor_cat_trip = 4'h0;
    logic local_thermal_vector_entry = 1'b0;
    logic forced_power_reduction_in = 1'b0;
    logic thermal_irq_ff, hot_indicator_n_ff, out_of_spec_condition_ff;
    logic catastrophic_trip_out_n, lowest_vf_settled, throttle_req = 1'b0;
    logic [7:0] target_temp = 8'h50;
    logic [7:0] sensor_temp;
    logic [63:0] d;
    int n_fail = 0;
    int samples_checked = 0;

    always #25 core_clk = ~core_clk;

    tto_monitor #(.NUM_SENSORS(4), .SAMPLE_CYC(SC), .OOS_CYC(OC)) i_tto_monitor (
        .core_clk(core_clk), .reset(reset), .msr_addr(msr_addr),
        .msr_rd(msr_rd), .msr_wr(msr_wr), .msr_wdata(msr_wdata),
        .msr_rdata_ff(msr_rdata_ff), .msr_rvalid_ff(msr_rvalid_ff),
        .sensor_temp(sensor_temp), .sensor_cat_trip(sensor_cat_trip),
        .local_thermal_vector_entry(local_thermal_vector_entry),
        .lowest_vf_settled(lowest_vf_settled),
        .forced_power_reduction_in(forced_power_reduction_in),
        .thermal_irq_ff(thermal_irq_ff),
        .hot_indicator_n_ff(hot_indicator_n_ff),
        .out_of_spec_condition_ff(out_of_spec_condition_ff),
        .catastrophic_trip_out_n(catastrophic_trip_out_n));

    tto_platform_model #(.SETTLE_DLY(8)) i_tto_platform_model (
        .core_clk(core_clk), .target_temp(target_temp),
        .throttle_req(throttle_req), .sensor_temp(sensor_temp),
        .lowest_vf_settled(lowest_vf_settled));

    // ========================================================
    // Checking and register access
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    task automatic chkb(input string nm, input logic e, input logic g);
        chk(nm, {63'h0, e}, {63'h0, g});
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [63:0] v);
        @(negedge core_clk);
        msr_addr = a;
        msr_wdata = v;
        msr_wr = 1'b1;
        @(negedge core_clk);
        msr_wr = 1'b0;
    endtask
    task automatic rd(input logic [31:0] a);
        @(negedge core_clk);
        msr_addr = a;
        msr_rd = 1'b1;
        @(negedge core_clk);
        msr_rd = 1'b0;
        chkb("read valid", 1'b1, msr_rvalid_ff);
        d = msr_rdata_ff;
    endtask
    task automatic rbit(input string nm, input int pos, input logic e);
        rd(TTO_STAT_ADDR);
        chkb(nm, e, d[pos]);
    endtask
    task automatic thr(input int k, input int off, input logic en);
        wr(TTO_CTRL_ADDR, (64'(off) << (k ? TTO_CTRL_THR2_LSB : TTO_CTRL_THR1_LSB))
            | (64'(en) << (k ? TTO_CTRL_THR2_EN : TTO_CTRL_THR1_EN)));
    endtask
    // Hold a temperature for two refresh periods and count interrupts.
    task automatic step(input logic [7:0] t, input int e);
        int n;
        n = 0;
        @(negedge core_clk);
        target_temp = t;
        repeat (2 * SC) begin
            @(negedge core_clk);
            if (thermal_irq_ff === 1'b1) n++;
        end
        chk("irq count", 64'(e), 64'(n));
    endtask
    task automatic wait_oos(input int lim);
        for (int i = 0; i < lim && out_of_spec_condition_ff !== 1'b1; i++) begin
            @(negedge core_clk);
        end
        chkb("oos pin", 1'b1, out_of_spec_condition_ff);
        if (out_of_spec_condition_ff !== 1'b1) begin
            test_done();
        end
    endtask

    initial begin
        repeat (100000) @(posedge core_clk);
        n_fail++;
        test_done();
    end

    // ========================================================
    // Scenarios
    initial begin
        repeat (5) @(negedge core_clk);
        reset = 1'b0;
        rd(TTO_CTRL_ADDR);
        chk("ctrl reset", TTO_CTRL_RESET, d);
        chkb("hot pin", 1'b1, hot_indicator_n_ff);
        wr(TTO_CTRL_ADDR, {64{1'b1}});
        rd(TTO_CTRL_ADDR);
        chk("ctrl mask", TTO_CTRL_MASK, d);
        rd(32'h0000_01a0);
        chk("unmapped", TTO_CTRL_RESET, d);
        wr(TTO_CTRL_ADDR, TTO_CTRL_RESET);
        for (int i = 0; i < 4; i++) begin
            @(negedge core_clk);
            sensor_cat_trip = 4'(1 << i);
            #1 chkb("cat pin", 1'b0, catastrophic_trip_out_n);
        end
        @(negedge core_clk);
        sensor_cat_trip = 4'h0;
        #1 chkb("cat pin", 1'b1, catastrophic_trip_out_n);
        $display("test registers done");
        local_thermal_vector_entry = 1'b1;
        step(8'h50, 0);
        for (int k = 0; k < 2; k++) begin
            thr(k, 10, 1'b1);
            wr(TTO_STAT_ADDR, TTO_CTRL_RESET);
            step(8'h5f, 1);
            rbit("thr status", k ? TTO_STAT_THR2 : TTO_STAT_THR1, 1'b1);
            rbit("thr log", k ? TTO_STAT_THR2_LOG : TTO_STAT_THR1_LOG, 1'b1);
            step(8'h55, 1);
            rbit("thr status", k ? TTO_STAT_THR2 : TTO_STAT_THR1, 1'b0);
            thr(k, 10, 1'b0);
            step(8'h5f, 0);
            thr(k, 10, 1'b1);
            local_thermal_vector_entry = 1'b0;
            step(8'h55, 0);
            local_thermal_vector_entry = 1'b1;
        end
        $display("test thresholds done");
        thr(0, 10, 1'b1);
        step(8'h5f, 1);
        wr(TTO_STAT_ADDR, TTO_CTRL_RESET);
        thr(0, 5, 1'b1);
        step(8'h5f, 0);
        rbit("thr status", TTO_STAT_THR1, 1'b1);
        rbit("thr log", TTO_STAT_THR1_LOG, 1'b0);
        thr(0, 4, 1'b1);
        step(8'h5f, 0);
        rbit("thr status", TTO_STAT_THR1, 1'b0);
        thr(0, 2, 1'b1);
        step(8'h63, 1);
        $display("test reprogram done");
        wr(TTO_CTRL_ADDR, (64'h1 << TTO_CTRL_HIGH_EN)
            | (64'h1 << TTO_CTRL_LOW_EN));
        step(8'h65, 0);
        chkb("hot pin", 1'b1, hot_indicator_n_ff);
        step(8'h6e, 1);
        chkb("hot pin", 1'b0, hot_indicator_n_ff);
        rbit("hot status", TTO_STAT_HOT, 1'b1);
        step(8'h63, 0);
        chkb("hot pin", 1'b0, hot_indicator_n_ff);
        step(8'h5a, 1);
        chkb("hot pin", 1'b1, hot_indicator_n_ff);
        rd(TTO_STAT_ADDR);
        chk("readout", 64'(TTO_TRIP_TEMP - 8'h5a),
            64'(d[TTO_STAT_READ_LSB +: TTO_OFFSET_W]));
        wr(TTO_CTRL_ADDR, TTO_CTRL_RESET);
        $display("test hysteresis done");
        step(8'h6e, 0);
        step(8'h6e, 0);
        chkb("oos pin", 1'b0, out_of_spec_condition_ff);
        forced_power_reduction_in = 1'b1;
        throttle_req = 1'b1;
        step(8'h6e, 0);
        step(8'h6e, 0);
        chkb("oos pin", 1'b0, out_of_spec_condition_ff);
        forced_power_reduction_in = 1'b0;
        repeat (SC) @(negedge core_clk);
        chkb("oos pin", 1'b0, out_of_spec_condition_ff);
        step(8'h5a, 0);
        step(8'h6e, 0);
        chkb("oos pin", 1'b0, out_of_spec_condition_ff);
        wait_oos(4 * OC);
        wr(TTO_STAT_ADDR, TTO_CTRL_RESET);
        rbit("oos status", TTO_STAT_OOS, 1'b1);
        rbit("oos log", TTO_STAT_OOS_LOG, 1'b1);
        throttle_req = 1'b0;
        step(8'h50, 0);
        chkb("oos pin", 1'b1, out_of_spec_condition_ff);
        @(negedge core_clk);
        reset = 1'b1;
        repeat (5) @(negedge core_clk);
        reset = 1'b0;
        chkb("oos pin", 1'b0, out_of_spec_condition_ff);
        rd(TTO_CTRL_ADDR);
        chk("ctrl reset", TTO_CTRL_RESET, d);
        wr(TTO_CTRL_ADDR, 64'h1 << TTO_CTRL_OOS_EN);
        target_temp = 8'h7a;
        wait_oos(4 * SC);
        step(8'h7a, 1);
        $display("test out of spec done");
        test_done();
    end
endmodule // thermal_threshold_oos_monitor_tb_top
`default_nettype wire

// [tb/tto_platform_model.sv]
// Platform model: sensor temperature source and voltage/frequency settling.
`timescale 1ns/1ns
`default_nettype none
module tto_platform_model #(
    parameter int SETTLE_DLY = 8
) (
    input wire logic core_clk,
    input wire logic [7:0] target_temp,
    input wire logic throttle_req,
    output var logic [7:0] sensor_temp,
    output var logic lowest_vf_settled
);
    int settle_cnt = 0;
    initial begin
        sensor_temp = 8'h50;
        lowest_vf_settled = 1'b0;
    end
    // The die may jump several degrees within one period.
    always @(negedge core_clk) begin
        sensor_temp <= target_temp;
    end
    // The lowest point is reached some cycles after throttling.
    always @(negedge core_clk) begin
        if (!throttle_req) begin
            settle_cnt <= 0;
        end else if (settle_cnt < SETTLE_DLY) begin
            settle_cnt <= settle_cnt + 1;
        end
        lowest_vf_settled <= throttle_req && (settle_cnt >= SETTLE_DLY);
    end
endmodule // tto_platform_model
`default_nettype wire
